// ==== src/podb_top.sv ====
// Output divider bank: reference select, prescalers, five dividers.
// Assumes osc_tick pulses once per oscillator period, synchronous to pclk.
`timescale 1ns/1ps
module podb_top #(
  parameter int NUM_DIV = podb_pkg::NUM_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic primary_reference_pair,
  input wire logic secondary_reference_pair,
  input wire logic osc_tick,
  input wire logic freq_lock,
  input wire logic phase_lock,
  output logic [NUM_DIV-1:0] clk_out,
  output logic ref_prescaled,
  output logic feedback_prescaled,
  output logic lock_n,
  output logic skew_enable
);
  localparam int VW = podb_pkg::VW;
  localparam int PW = podb_pkg::PW;
  localparam int SELW = podb_pkg::SELW;

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic bypass_reg;
  logic reference_pair_choice_reg;
  logic [SELW-1:0] fb_sel_reg;
  logic [PW-1:0] m_div_reg;
  logic [PW-1:0] n_div_reg;
  logic [VW-1:0] v_div_reg [NUM_DIV];
  logic [NUM_DIV-1:0] invert_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic fb_src;

  logic setup_ph;
  logic wr_en;
  logic [PW-1:0] pw_clamped;
  logic [VW-1:0] vw_clamped;
  logic [31:0] rd_next;
  logic err_next;
  logic vdiv_hit;
  logic [SELW-1:0] vdiv_idx;

  assign setup_ph = psel && !penable;
  assign wr_en = psel && penable && pready_reg && pwrite && !pslverr_reg;
  assign vdiv_hit = paddr >= podb_pkg::ADDR_VDIV0 &&
                    paddr <= podb_pkg::ADDR_VDIV4 && paddr[1:0] == 2'h0;
  assign vdiv_idx = SELW'((paddr - podb_pkg::ADDR_VDIV0) >> 2);

  ////////////////////////////////////////////////////////////////////////
  // Value conditioning on write
  always_comb
  begin
    if (pwdata[PW-1:0] < podb_pkg::P_MIN)
    begin
      pw_clamped = podb_pkg::P_MIN;
    end
    else if (pwdata[PW-1:0] > podb_pkg::P_MAX)
    begin
      pw_clamped = podb_pkg::P_MAX;
    end
    else
    begin
      pw_clamped = pwdata[PW-1:0];
    end
  end

  always_comb
  begin
    // Odd requests round down to the next even ratio
    vw_clamped = {pwdata[VW-1:1], 1'b0};
    if (vw_clamped < podb_pkg::V_MIN)
    begin
      vw_clamped = podb_pkg::V_MIN;
    end
    else if (vw_clamped > podb_pkg::V_MAX)
    begin
      vw_clamped = podb_pkg::V_MAX;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave: no wait states, answer prepared in setup phase
  always_comb
  begin
    rd_next = podb_pkg::RD_ZERO;
    err_next = 1'b0;
    case (paddr)
      podb_pkg::ADDR_CTRL:
      begin
        rd_next[podb_pkg::CTRL_BYPASS] = bypass_reg;
        rd_next[podb_pkg::CTRL_REF_CHOICE] = reference_pair_choice_reg;
        rd_next[podb_pkg::CTRL_FBSEL_LO +: SELW] = fb_sel_reg;
      end
      podb_pkg::ADDR_MDIV:
      begin
        rd_next[PW-1:0] = m_div_reg;
      end
      podb_pkg::ADDR_NDIV:
      begin
        rd_next[PW-1:0] = n_div_reg;
      end
      podb_pkg::ADDR_STATUS:
      begin
        rd_next[podb_pkg::ST_LOCK] = !lock_n;
        rd_next[podb_pkg::ST_BYPASS] = bypass_reg;
        rd_next[podb_pkg::ST_OUT_LO +: NUM_DIV] = clk_out;
        rd_next[podb_pkg::ST_FBOUT] = fb_src;
      end
      default:
      begin
        if (vdiv_hit && vdiv_idx < SELW'(NUM_DIV))
        begin
          rd_next[VW-1:0] = v_div_reg[vdiv_idx];
          rd_next[podb_pkg::VDIV_INV] = invert_reg[vdiv_idx];
        end
        else
        begin
          err_next = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= podb_pkg::RD_ZERO;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= setup_ph;
      pslverr_reg <= setup_ph && err_next;
      if (setup_ph && !pwrite)
      begin
        prdata_reg <= rd_next;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bypass_reg <= 1'b0;
      reference_pair_choice_reg <= 1'b0;
      fb_sel_reg <= '0;
      m_div_reg <= podb_pkg::P_RESET;
      n_div_reg <= podb_pkg::P_RESET;
    end
    else if (wr_en)
    begin
      if (paddr == podb_pkg::ADDR_CTRL)
      begin
        bypass_reg <= pwdata[podb_pkg::CTRL_BYPASS];
        reference_pair_choice_reg <= pwdata[podb_pkg::CTRL_REF_CHOICE];
        // Out-of-range selects fall back to the first divider
        if (pwdata[podb_pkg::CTRL_FBSEL_LO +: SELW] < SELW'(NUM_DIV))
        begin
          fb_sel_reg <= pwdata[podb_pkg::CTRL_FBSEL_LO +: SELW];
        end
        else
        begin
          fb_sel_reg <= '0;
        end
      end
      if (paddr == podb_pkg::ADDR_MDIV)
      begin
        m_div_reg <= pw_clamped;
      end
      if (paddr == podb_pkg::ADDR_NDIV)
      begin
        n_div_reg <= pw_clamped;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_DIV; i++)
      begin
        v_div_reg[i] <= podb_pkg::V_RESET;
      end
      invert_reg <= '0;
    end
    else if (wr_en && vdiv_hit && vdiv_idx < SELW'(NUM_DIV))
    begin
      v_div_reg[vdiv_idx] <= vw_clamped;
      invert_reg[vdiv_idx] <= pwdata[podb_pkg::VDIV_INV];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reference selection and input prescaler
  logic ref_sel;
  logic ref_prev_reg;
  logic ref_edge;
  logic m_tick;

  // Low picks the primary pair, high the secondary
  assign ref_sel = reference_pair_choice_reg ? secondary_reference_pair
                                             : primary_reference_pair;
  assign ref_edge = ref_sel && !ref_prev_reg;

  podb_prescaler #(.PW(PW)) u_m_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(ref_edge),
    .div(m_div_reg),
    .tick_out(m_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Lock resynchronisation and divider clocking
  logic freq_lock_prev_reg;
  logic lock_rise;
  logic [NUM_DIV-1:0] div_out;
  podb_div_if dctl ();

  // Only the frequency detector restarts dividers, and only outside bypass
  assign lock_rise = freq_lock && !freq_lock_prev_reg && !bypass_reg;
  // Bypass clocks dividers from the prescaled reference
  assign dctl.tick = bypass_reg ? m_tick : osc_tick;
  assign dctl.resync = lock_rise;
  assign dctl.bypass = bypass_reg;

  genvar g;
  generate
    for (g = 0; g < NUM_DIV; g++)
    begin : g_div
      podb_out_div #(.VW(VW)) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .ctl(dctl),
        .v(v_div_reg[g]),
        .div_out(div_out[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Feedback path and outputs
  logic fb_prev_reg;
  logic n_tick;

  // Chosen divider still drives its own output too
  assign fb_src = div_out[fb_sel_reg];

  // Edge history reset low; ref and lock idle low, but the feedback divider output starts high, so one edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_prev_reg <= 1'b0;
      freq_lock_prev_reg <= 1'b0;
      fb_prev_reg <= 1'b0;
    end
    else
    begin
      ref_prev_reg <= ref_sel;
      freq_lock_prev_reg <= freq_lock;
      fb_prev_reg <= fb_src;
    end
  end

  podb_prescaler #(.PW(PW)) u_n_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(fb_src && !fb_prev_reg),
    .div(n_div_reg),
    .tick_out(n_tick)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_out <= '0;
      ref_prescaled <= 1'b0;
      feedback_prescaled <= 1'b0;
      lock_n <= 1'b1;
      skew_enable <= 1'b0;
    end
    else
    begin
      // Inversion complements duty and can align half-duty edges
      clk_out <= div_out ^ invert_reg;
      ref_prescaled <= m_tick;
      feedback_prescaled <= n_tick && !bypass_reg;
      // Lock report and skew both off in bypass
      lock_n <= bypass_reg || !(freq_lock || phase_lock);
      skew_enable <= !bypass_reg;
    end
  end
endmodule

// ==== include/podb_pkg.sv ====
// Package for the post-loop output divider bank.
// Assumes a 100 MHz APB clock and a synchronous one-cycle oscillator tick.
package podb_pkg;
  localparam int NUM_DIV = 5;
  localparam int VW = 7;
  localparam int PW = 6;
  localparam int SELW = 3;
  localparam int CLK_MHZ = 100;
  localparam int OSC_MIN_MHZ = 320;
  localparam int OSC_MAX_MHZ = 640;
  localparam int REF_MIN_MHZ = 10;
  localparam int FB_PRODUCT_MAX = 64;
  localparam logic [VW-1:0] V_MIN = 7'h02;
  localparam logic [VW-1:0] V_MAX = 7'h40;
  localparam logic [PW-1:0] P_MIN = 6'h01;
  localparam logic [PW-1:0] P_MAX = 6'h20;
  localparam logic [VW-1:0] V_RESET = 7'h02;
  localparam logic [PW-1:0] P_RESET = 6'h01;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_MDIV = 12'h004;
  localparam logic [11:0] ADDR_NDIV = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_VDIV0 = 12'h010;
  localparam logic [11:0] ADDR_VDIV4 = 12'h020;
  localparam int CTRL_BYPASS = 0;
  localparam int CTRL_REF_CHOICE = 1;
  localparam int CTRL_FBSEL_LO = 4;
  localparam int VDIV_INV = 8;
  localparam int ST_LOCK = 0;
  localparam int ST_BYPASS = 1;
  localparam int ST_OUT_LO = 8;
  localparam int ST_FBOUT = 16;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

// ==== include/podb_div_if.sv ====
// Shared timing carrier from the bank to each output divider.
// Assumes one source and any number of divider sinks.
`timescale 1ns/1ps
interface podb_div_if;
  logic tick;
  logic resync;
  logic bypass;
  modport src (output tick, output resync, output bypass);
  modport sink (input tick, input resync, input bypass);
endinterface

// ==== src/podb_prescaler.sv ====
// Integer prescaler: one output pulse per DIV input pulses.
// Assumes div is kept within 1..32 by the register logic.
`timescale 1ns/1ps
module podb_prescaler #(
  parameter int PW = podb_pkg::PW
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick_in,
  input wire logic [PW-1:0] div,
  output logic tick_out
);
  logic [PW-1:0] cnt_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= '0;
    end
    else if (tick_in)
    begin
      if (cnt_reg + PW'(1) >= div)
      begin
        cnt_reg <= '0;
      end
      else
      begin
        cnt_reg <= cnt_reg + PW'(1);
      end
    end
  end

  // Divide by one passes every input pulse
  assign tick_out = tick_in && (cnt_reg + PW'(1) >= div);
endmodule

// ==== src/podb_out_div.sv ====
// One even-ratio output divider with lock resynchronisation.
// Assumes v is even and within 2..64.
`timescale 1ns/1ps
module podb_out_div #(
  parameter int VW = podb_pkg::VW
) (
  input wire logic pclk,
  input wire logic presetn,
  podb_div_if.sink ctl,
  input wire logic [VW-1:0] v,
  output logic div_out
);
  logic [VW-1:0] period;
  logic [VW-1:0] high_len;
  logic [VW-1:0] cnt_reg;
  logic half_duty;

  // Bypass halves the nominal ratio
  assign period = ctl.bypass ? (v >> 1) : v;
  // Ratio 2 outside bypass, or multiples of 4, give exact half duty
  assign half_duty = (v == podb_pkg::V_MIN) || (v[1:0] == 2'h0);
  always_comb
  begin
    if (ctl.bypass)
    begin
      high_len = (period >> 1) == '0 ? VW'(1) : (period >> 1);
    end
    else if (half_duty)
    begin
      high_len = v >> 1;
    end
    else
    begin
      high_len = (v >> 1) - VW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= '0;
    end
    else if (ctl.resync)
    begin
      // Equal divisors restart together, so edges coincide
      cnt_reg <= '0;
    end
    else if (ctl.tick)
    begin
      if (cnt_reg + VW'(1) >= period)
      begin
        cnt_reg <= '0;
      end
      else
      begin
        cnt_reg <= cnt_reg + VW'(1);
      end
    end
  end

  // Different divisors realign at the restart and at every common multiple of their periods
  assign div_out = cnt_reg < high_len;
endmodule

// ==== tb/podb_ref_src.sv ====
// Reference pair and oscillator tick source facing the bank.
// Assumes one pclk domain; references run free.
`timescale 1ns/1ps
module podb_ref_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic osc_stall,
  output logic primary_reference_pair,
  output logic secondary_reference_pair,
  output logic osc_tick
);
  logic [1:0] phase_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase_reg <= 2'h0;
    else
      phase_reg <= phase_reg + 2'h1;
  end
  // Tick per cycle stands for the scaled oscillator
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      osc_tick <= 1'b0;
    else
      osc_tick <= !osc_stall;
  end
  // Rises every 2 and 4 cycles, so the chosen pair shows
  assign primary_reference_pair = phase_reg[0];
  assign secondary_reference_pair = phase_reg[1];
endmodule

// ==== tb/podb_checker.sv ====
// Port checker for the output divider bank.
// Assumes a bind onto podb_top, single pclk domain.
`timescale 1ns/1ps
module podb_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic freq_lock,
  input wire logic phase_lock,
  input wire logic ref_prescaled,
  input wire logic feedback_prescaled,
  input wire logic lock_n,
  input wire logic skew_enable
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_setup_ready:
    assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_ready_single:
    assert property (pready |=> !pready)
    else $error("pready held too long");
  a_idle_quiet:
    assert property (!psel |=> !pready)
    else $error("pready without setup");
  a_err_ready:
    assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_zero:
    assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read data not zero");
  a_bypass_quiet:
    assert property (!skew_enable |-> lock_n && !feedback_prescaled)
    else $error("lock or feedback active in bypass");
  a_lock_level:
    assert property (1'b1 |=> lock_n ==
      !(($past(freq_lock) || $past(phase_lock)) && skew_enable))
    else $error("lock_n wrong");
  a_ref_pulse:
    assert property (ref_prescaled |=> !ref_prescaled)
    else $error("ref pulse too long");
  a_fb_pulse:
    assert property (feedback_prescaled |=> !feedback_prescaled)
    else $error("feedback pulse too long");
  c_err: cover property (pready && pslverr);
  c_bypass: cover property (!skew_enable && ref_prescaled);
  c_lock: cover property ($rose(freq_lock) && skew_enable);
endmodule
bind podb_top podb_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .freq_lock(freq_lock), .phase_lock(phase_lock),
  .ref_prescaled(ref_prescaled), .feedback_prescaled(feedback_prescaled),
  .lock_n(lock_n), .skew_enable(skew_enable)
);

// ==== tb/podb_top_test.sv ====
// Self-checking bench for the output divider bank.
// Assumes podb_pkg compiled first; APB master drives on rising edges.
`timescale 1ns/1ps
module podb_top_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic freq_lock, phase_lock, osc_stall, osc_tick, lock_n;
  logic primary_reference_pair, secondary_reference_pair;
  logic [4:0] clk_out, inv, b;
  logic ref_prescaled, feedback_prescaled, skew_enable;
  int err_count, cmp_count, seed;
  int vt [8] = '{2, 4, 6, 10, 14, 30, 62, 64};
  int v [5];
  podb_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .primary_reference_pair(primary_reference_pair),
    .secondary_reference_pair(secondary_reference_pair),
    .osc_tick(osc_tick), .freq_lock(freq_lock), .phase_lock(phase_lock),
    .clk_out(clk_out), .ref_prescaled(ref_prescaled),
    .feedback_prescaled(feedback_prescaled), .lock_n(lock_n),
    .skew_enable(skew_enable));
  podb_ref_src u_ref (.pclk(pclk), .presetn(presetn),
    .osc_stall(osc_stall), .osc_tick(osc_tick),
    .primary_reference_pair(primary_reference_pair),
    .secondary_reference_pair(secondary_reference_pair));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task end_sim();
    $display("mismatches %0d, comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task tmo();
    err_count++;
    $display("wrong value at %0t: wait timed out", $time);
    end_sim();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic int exp_hi(input int vv, input logic i);
    int h;
    h = (vv == 2 || vv % 4 == 0) ? vv / 2 : vv / 2 - 1;
    return i ? vv - h : h;
  endfunction
  function automatic logic [11:0] vaddr(input int k);
    return podb_pkg::ADDR_VDIV0 + 12'(4 * k);
  endfunction
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d = 32'h0);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      tmo();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a);
    chk(rd, e);
  endtask
  // Waits a rising edge, then times one high and one low phase
  task automatic meas_chk(input int k, input int eh, input int el);
    int hi = 0, lo = 0, n = 0;
    while (clk_out[k] !== 1'b0 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    while (clk_out[k] !== 1'b1 && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    while (clk_out[k] === 1'b1 && n < 600)
    begin
      @(posedge pclk);
      hi++;
      n++;
    end
    while (clk_out[k] === 1'b0 && n < 800)
    begin
      @(posedge pclk);
      lo++;
      n++;
    end
    if (n >= 800)
      tmo();
    chk(hi, eh);
    chk(lo, el);
  endtask
  // Window of 60 holds whole periods, so the count is exact
  task automatic cnt_chk(input logic fb, input int e);
    int c = 0;
    repeat (20) @(posedge pclk);
    repeat (60)
    begin
      @(posedge pclk);
      if ((fb ? feedback_prescaled : ref_prescaled) === 1'b1)
        c++;
    end
    chk(c, e);
  endtask
  task automatic set_all();
    for (int k = 0; k < 5; k++)
      apb(1'b1, vaddr(k), {23'h0, inv[k], 1'b0, 7'(v[k])});
    freq_lock <= 1'b0;
    @(posedge pclk);
    freq_lock <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'hBAE748DC;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {freq_lock, phase_lock, osc_stall, presetn} = 4'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk(podb_pkg::ADDR_CTRL, 32'h0);
    rchk(podb_pkg::ADDR_MDIV, 32'h1);
    rchk(podb_pkg::ADDR_NDIV, 32'h1);
    for (int k = 0; k < 5; k++)
      rchk(vaddr(k), 32'h2);
    apb(1'b1, podb_pkg::ADDR_NDIV, 32'h0);
    rchk(podb_pkg::ADDR_NDIV, 32'h1);
    apb(1'b1, podb_pkg::ADDR_NDIV, 32'h28);
    rchk(podb_pkg::ADDR_NDIV, 32'h20);
    apb(1'b1, podb_pkg::ADDR_VDIV4, 32'h107);
    rchk(podb_pkg::ADDR_VDIV4, 32'h106);
    apb(1'b1, podb_pkg::ADDR_VDIV0, 32'h7F);
    rchk(podb_pkg::ADDR_VDIV0, 32'h40);
    apb(1'b1, podb_pkg::ADDR_STATUS, 32'hFFFFFFFF);
    apb(1'b0, podb_pkg::ADDR_STATUS);
    chk(rd & 32'h2, 32'h0);
    apb(1'b1, 12'h024, 32'hFF);
    chk(er, 1'b1);
    rchk(12'h024, 32'h0);
    chk(er, 1'b1);
    // Feedback from divider 2, ratio 6
    apb(1'b1, podb_pkg::ADDR_NDIV, 32'h1);
    apb(1'b1, vaddr(2), 32'h6);
    apb(1'b1, podb_pkg::ADDR_CTRL, 32'h20);
    cnt_chk(1'b1, 10);
    apb(1'b1, podb_pkg::ADDR_NDIV, 32'h2);
    cnt_chk(1'b1, 5);
    apb(1'b1, podb_pkg::ADDR_CTRL, 32'h50);
    rchk(podb_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, podb_pkg::ADDR_MDIV, 32'h3);
    cnt_chk(1'b0, 10);
    // Table of ratios, then random ratios; inversions random throughout
    for (int t = 0; t < 12; t++)
    begin
      for (int k = 0; k < 5; k++)
        v[k] = (t < 8) ? vt[t] : 2 + 2 * ($unsigned($random(seed)) % 32);
      inv = 5'($random(seed));
      phase_lock <= 1'($random(seed));
      set_all();
      if (t < 8)
        repeat (2 * vt[t])
        begin
          @(posedge pclk);
          chk((clk_out ^ inv) == 5'h0 || (clk_out ^ inv) == 5'h1F, 1);
        end
      if (t == 3)
      begin
        osc_stall <= 1'b1;
        repeat (4) @(posedge pclk);
        b = clk_out;
        repeat (6) @(posedge pclk);
        chk(clk_out, b);
        osc_stall <= 1'b0;
      end
      for (int k = 0; k < 5; k++)
        meas_chk(k, exp_hi(v[k], inv[k]), v[k] - exp_hi(v[k], inv[k]));
    end
    // Bypass: M 2, ratio 8 halved to 4
    apb(1'b1, podb_pkg::ADDR_MDIV, 32'h2);
    apb(1'b1, podb_pkg::ADDR_VDIV0, 32'h8);
    apb(1'b1, podb_pkg::ADDR_CTRL, 32'h1);
    apb(1'b0, podb_pkg::ADDR_STATUS);
    chk(rd & 32'h2, 32'h2);
    chk(skew_enable, 1'b0);
    meas_chk(0, 8, 8);
    cnt_chk(1'b1, 0);
    apb(1'b1, podb_pkg::ADDR_CTRL, 32'h3);
    meas_chk(0, 16, 16);
    apb(1'b1, podb_pkg::ADDR_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    chk(skew_enable, 1'b1);
    end_sim();
  end
endmodule
